// ===== inc/hvwk_consts.vh
// constants of the high-voltage wake input detector: register map, fields, timing
// assumes a 100 MHz mclk and a 32-bit apb register bus
`ifndef HVWK_CONSTS_VH
`define HVWK_CONSTS_VH

// register byte offsets
`define HVWK_OFS_CTRL      12'h000
`define HVWK_OFS_EVT_STAT  12'h004
`define HVWK_OFS_ALT_STAT  12'h008
`define HVWK_OFS_LVL_STAT  12'h00c
`define HVWK_OFS_BIAS      12'h010
`define HVWK_OFS_IRQ_CLR   12'h014
`define HVWK_OFS_IRQ_EN    12'h018
`define HVWK_ADDR_W        12

// wake_control_reg fields
`define HVWK_CTRL_PIN_EN   0
`define HVWK_CTRL_CYCLIC   1
`define HVWK_CTRL_ALT_EN   2
`define HVWK_CTRL_W        3
`define HVWK_CTRL_RST      3'h0

// status, clear and enable fields
`define HVWK_EVT_PIN       0
`define HVWK_EVT_ALT       1
`define HVWK_EVT_W         2

// bias select codes
`define HVWK_BIAS_W        2
`define HVWK_BIAS_NONE     2'h0
`define HVWK_BIAS_DOWN     2'h1
`define HVWK_BIAS_UP       2'h2
`define HVWK_BIAS_AUTO     2'h3

// chip power modes on power_mode
`define HVWK_MODE_W        3
`define HVWK_MODE_NORMAL   3'h0
`define HVWK_MODE_STOP     3'h1
`define HVWK_MODE_SLEEP    3'h2
`define HVWK_MODE_FAILSAFE 3'h3
`define HVWK_MODE_INIT     3'h4

// deglitch filter timing
`define HVWK_FILT_TIME_NS  16000
`define HVWK_CLK_PERIOD_NS 10
`define HVWK_FILT_CYCLES   (`HVWK_FILT_TIME_NS / `HVWK_CLK_PERIOD_NS)
`define HVWK_FILT_CNT_W    12

`endif

// ===== src/hvwk_filter.v
// digital deglitch filter for one synchronised comparator level
// assumes din is already synchronised to clk
`timescale 1ns/1ps
`default_nettype none
`include "hvwk_consts.vh"

module hvwk_filter #(
	parameter CYCLES = `HVWK_FILT_CYCLES,
	parameter CNT_W  = `HVWK_FILT_CNT_W
) (
	input  wire clk,
	input  wire rst,
	input  wire din,
	output reg  level_reg,
	output reg  edge_reg
);

	// terminal count cut to the counter width on purpose
	localparam [31:0]      TERM32 = CYCLES - 1;
	localparam [CNT_W-1:0] TERM   = TERM32[CNT_W-1:0];
	localparam [CNT_W-1:0] ONE    = {{(CNT_W-1){1'b0}}, 1'b1};

	reg [CNT_W-1:0] cnt_reg;

	always @(posedge clk) begin
		if (rst) begin
			level_reg <= 1'b0;
			edge_reg  <= 1'b0;
			cnt_reg   <= {CNT_W{1'b0}};
		end else begin
			edge_reg <= 1'b0;
			if (din == level_reg) begin
				// crossing back before the end restarts the interval
				cnt_reg <= {CNT_W{1'b0}};
			end else if (cnt_reg == TERM) begin
				// level held for the whole filter time: accept either edge
				level_reg <= din;
				edge_reg  <= 1'b1;
				cnt_reg   <= {CNT_W{1'b0}};
			end else begin
				cnt_reg <= cnt_reg + ONE;
			end
		end
	end

endmodule
`default_nettype wire

// ===== src/hvwk_top.v
// high-voltage wake input detector with apb register access
// assumes comparator outputs are asynchronous; power_mode and hs_on come from mclk logic
//
// Functional notes
// - both rising and falling crossings of the wake pin are wake events.
// - events interrupt in Normal/Stop, and request wake-up in Sleep/Fail-Safe.
// - a control bit selects static sensing or cyclic windowed sensing.
// - static sensing applies a nominal 16 us deglitch filter.
// - filter starts at a crossing; event only if no crossing back in time.
// - a wake control bit enables or disables pin wake capability.
// - every pin wake event latches into the pin wake flag.
// - live pin level is readable in Normal, Stop and Init modes.
// - during cyclic sensing the level register shows the last sampled level.
// - alternate pin as wake input is filtered 16 us, latched separately.
// - software controls pin pull current sources through the bias register.
// - bias codes: 00 none (reset), 01 pull-down, 10 pull-up, 11 automatic.
// - automatic mode pulls up on high level, down on low level.
// - cyclic sensing samples only while the high-side switch is on.
//
// The register addresses and the APB interface to the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "hvwk_consts.vh"

module hvwk_top #(
	parameter FILT_CYCLES = `HVWK_FILT_CYCLES,
	parameter FILT_CNT_W  = `HVWK_FILT_CNT_W
) (
	input  wire                     mclk,
	input  wire                     sys_rst,
	// apb slave
	input  wire                     psel,
	input  wire                     penable,
	input  wire                     pwrite,
	input  wire [`HVWK_ADDR_W-1:0]  paddr,
	input  wire [31:0]              pwdata,
	output reg  [31:0]              prdata,
	output reg                      pready,
	output reg                      pslverr,
	// pin side
	input  wire                     hv_wake_pin,
	input  wire                     fail_output_gp_pin,
	input  wire                     high_side_switch,
	input  wire [`HVWK_MODE_W-1:0]  power_mode,
	output reg                      pull_up_en,
	output reg                      pull_down_en,
	// events to the rest of the chip
	output reg                      wake_irq,
	output reg                      wake_up_req
);

	// mode classes used by interrupt, wake-up and level readback
	function mode_active;
		input [`HVWK_MODE_W-1:0] m;
		begin
			mode_active = (m == `HVWK_MODE_NORMAL) || (m == `HVWK_MODE_STOP);
		end
	endfunction

	function mode_low_power;
		input [`HVWK_MODE_W-1:0] m;
		begin
			mode_low_power = (m == `HVWK_MODE_SLEEP) || (m == `HVWK_MODE_FAILSAFE);
		end
	endfunction

	function mode_readable;
		input [`HVWK_MODE_W-1:0] m;
		begin
			mode_readable = mode_active(m) || (m == `HVWK_MODE_INIT);
		end
	endfunction

	// pin synchronisers
	reg wk_s1_reg;
	reg wk_s2_reg;
	reg alt_s1_reg;
	reg alt_s2_reg;

	always @(posedge mclk) begin
		if (sys_rst) begin
			wk_s1_reg  <= 1'b0;
			wk_s2_reg  <= 1'b0;
			alt_s1_reg <= 1'b0;
			alt_s2_reg <= 1'b0;
		end else begin
			wk_s1_reg  <= hv_wake_pin;
			wk_s2_reg  <= wk_s1_reg;
			alt_s1_reg <= fail_output_gp_pin;
			alt_s2_reg <= alt_s1_reg;
		end
	end

	// static filters
	wire wk_filt_lvl;
	wire wk_filt_edge;
	wire alt_filt_lvl;
	wire alt_filt_edge;

	hvwk_filter #(
		.CYCLES (FILT_CYCLES),
		.CNT_W  (FILT_CNT_W)
	) u_wk_filter (
		.clk       (mclk),
		.rst       (sys_rst),
		.din       (wk_s2_reg),
		.level_reg (wk_filt_lvl),
		.edge_reg  (wk_filt_edge)
	);

	// alternate wake input always uses the static filter
	hvwk_filter #(
		.CYCLES (FILT_CYCLES),
		.CNT_W  (FILT_CNT_W)
	) u_alt_filter (
		.clk       (mclk),
		.rst       (sys_rst),
		.din       (alt_s2_reg),
		.level_reg (alt_filt_lvl),
		.edge_reg  (alt_filt_edge)
	);

	// registers
	reg [`HVWK_CTRL_W-1:0] wake_control_reg;
	reg [`HVWK_BIAS_W-1:0] wake_bias_control_reg;
	reg [`HVWK_EVT_W-1:0]  wake_irq_enable_reg;
	reg                    pin_wake_flag_reg;
	reg                    alt_wake_flag_reg;

	wire pin_en    = wake_control_reg[`HVWK_CTRL_PIN_EN];
	wire cyclic_en = wake_control_reg[`HVWK_CTRL_CYCLIC];
	wire alt_en    = wake_control_reg[`HVWK_CTRL_ALT_EN];

	// cyclic sensing: capture the level during the switch on-time,
	// judge it when the on-time ends so the sensed node has settled
	reg hs_on_d_reg;
	reg on_lvl_reg;
	reg cyc_lvl_reg;
	reg cyc_edge_reg;

	always @(posedge mclk) begin
		if (sys_rst) begin
			hs_on_d_reg  <= 1'b0;
			on_lvl_reg   <= 1'b0;
			cyc_lvl_reg  <= 1'b0;
			cyc_edge_reg <= 1'b0;
		end else begin
			hs_on_d_reg  <= high_side_switch;
			cyc_edge_reg <= 1'b0;
			if (high_side_switch) begin
				on_lvl_reg <= wk_s2_reg; // sample only while switch is on
			end
			if (cyclic_en && hs_on_d_reg && !high_side_switch) begin
				cyc_lvl_reg <= on_lvl_reg;
				// change of the sampled level is a wake event
				cyc_edge_reg <= (on_lvl_reg != cyc_lvl_reg);
			end
		end
	end

	// detection mode select
	wire pin_edge   = cyclic_en ? cyc_edge_reg : wk_filt_edge;
	wire pin_level  = cyclic_en ? cyc_lvl_reg : wk_filt_lvl;
	wire pin_event  = pin_en && pin_edge;
	wire alt_event  = alt_en && alt_filt_edge;

	// apb access decode
	wire apb_setup_acc = psel && penable && !pready;
	wire apb_done      = psel && penable && pready;
	wire wr_done       = apb_done && pwrite;

	wire addr_ctrl = (paddr == `HVWK_OFS_CTRL);
	wire addr_evt  = (paddr == `HVWK_OFS_EVT_STAT);
	wire addr_alt  = (paddr == `HVWK_OFS_ALT_STAT);
	wire addr_lvl  = (paddr == `HVWK_OFS_LVL_STAT);
	wire addr_bias = (paddr == `HVWK_OFS_BIAS);
	wire addr_clr  = (paddr == `HVWK_OFS_IRQ_CLR);
	wire addr_en   = (paddr == `HVWK_OFS_IRQ_EN);
	wire addr_hit  = addr_ctrl | addr_evt | addr_alt | addr_lvl |
	                 addr_bias | addr_clr | addr_en;

	wire clr_pin = wr_done && addr_clr && pwdata[`HVWK_EVT_PIN];
	wire clr_alt = wr_done && addr_clr && pwdata[`HVWK_EVT_ALT];

	// level readback: live in static, last sample in cyclic, zero outside readable modes
	reg level_stat_reg;

	always @(posedge mclk) begin
		if (sys_rst) begin
			level_stat_reg <= 1'b0;
		end else begin
			level_stat_reg <= mode_readable(power_mode) && pin_level;
		end
	end

	// software writable registers
	always @(posedge mclk) begin
		if (sys_rst) begin
			wake_control_reg      <= `HVWK_CTRL_RST;
			wake_bias_control_reg <= `HVWK_BIAS_NONE;
			wake_irq_enable_reg   <= {`HVWK_EVT_W{1'b0}};
		end else if (wr_done) begin
			if (addr_ctrl) begin
				wake_control_reg <= pwdata[`HVWK_CTRL_W-1:0];
			end
			if (addr_bias) begin
				wake_bias_control_reg <= pwdata[`HVWK_BIAS_W-1:0];
			end
			if (addr_en) begin
				wake_irq_enable_reg <= pwdata[`HVWK_EVT_W-1:0];
			end
		end
	end

	// sticky event flags; a new event beats a clear in the same cycle
	always @(posedge mclk) begin
		if (sys_rst) begin
			pin_wake_flag_reg <= 1'b0;
			alt_wake_flag_reg <= 1'b0;
		end else begin
			if (pin_event) begin
				pin_wake_flag_reg <= 1'b1;
			end else if (clr_pin) begin
				pin_wake_flag_reg <= 1'b0;
			end
			if (alt_event) begin
				alt_wake_flag_reg <= 1'b1;
			end else if (clr_alt) begin
				alt_wake_flag_reg <= 1'b0;
			end
		end
	end

	// read data mux
	reg [31:0] rd_data;

	always @* begin
		rd_data = 32'h0000_0000;
		case (1'b1)
			addr_ctrl: rd_data[`HVWK_CTRL_W-1:0] = wake_control_reg;
			addr_evt:  rd_data[0] = pin_wake_flag_reg;
			addr_alt:  rd_data[0] = alt_wake_flag_reg;
			addr_lvl:  rd_data[0] = level_stat_reg;
			addr_bias: rd_data[`HVWK_BIAS_W-1:0] = wake_bias_control_reg;
			addr_en:   rd_data[`HVWK_EVT_W-1:0] = wake_irq_enable_reg;
			default:   rd_data = 32'h0000_0000;
		endcase
	end

	// apb answer: one wait state so that every bus output is a flip-flop
	always @(posedge mclk) begin
		if (sys_rst) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else if (apb_setup_acc) begin
			pready  <= 1'b1;
			pslverr <= !addr_hit;
			prdata  <= pwrite ? 32'h0000_0000 : rd_data;
		end else begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end
	end

	// interrupt and wake-up; interrupt is held off in low-power modes
	// because the host cannot service it there
	wire [`HVWK_EVT_W-1:0] flags;
	assign flags[`HVWK_EVT_PIN] = pin_wake_flag_reg;
	assign flags[`HVWK_EVT_ALT] = alt_wake_flag_reg;

	always @(posedge mclk) begin
		if (sys_rst) begin
			wake_irq    <= 1'b0;
			wake_up_req <= 1'b0;
		end else begin
			wake_irq    <= mode_active(power_mode) &&
			               (|(flags & wake_irq_enable_reg));
			wake_up_req <= mode_low_power(power_mode) &&
			               (pin_event || alt_event);
		end
	end

	// pin bias sources; automatic mode follows the detected level
	always @(posedge mclk) begin
		if (sys_rst) begin
			pull_up_en   <= 1'b0;
			pull_down_en <= 1'b0;
		end else begin
			case (wake_bias_control_reg)
				`HVWK_BIAS_DOWN: begin
					pull_up_en   <= 1'b0;
					pull_down_en <= 1'b1;
				end
				`HVWK_BIAS_UP: begin
					pull_up_en   <= 1'b1;
					pull_down_en <= 1'b0;
				end
				`HVWK_BIAS_AUTO: begin
					pull_up_en   <= pin_level;
					pull_down_en <= !pin_level;
				end
				default: begin
					pull_up_en   <= 1'b0;
					pull_down_en <= 1'b0;
				end
			endcase
		end
	end

endmodule
`default_nettype wire

// ===== testbench/hvwk_checker.sv
// port checker of the wake detector
// bound into hvwk_top; every assertion runs on mclk
`timescale 1ns/1ps
`default_nettype none
`include "hvwk_consts.vh"
module hvwk_checker #(
	parameter FILT_CYCLES = `HVWK_FILT_CYCLES,
	parameter FILT_CNT_W  = `HVWK_FILT_CNT_W
) (
	input wire logic        mclk,
	input wire logic        sys_rst,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        hv_wake_pin,
	input wire logic        fail_output_gp_pin,
	input wire logic        high_side_switch,
	input wire logic [2:0]  power_mode,
	input wire logic        pull_up_en,
	input wire logic        pull_down_en,
	input wire logic        wake_irq,
	input wire logic        wake_up_req
);
	default clocking @(posedge mclk); endclocking
	default disable iff (sys_rst);
	a_ready_wait: assert property (psel && penable && !pready |=> pready)
		else $error("no answer one cycle into access");
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("pready held too long");
	a_err_map: assert property (pready |-> pslverr == (paddr > `HVWK_OFS_IRQ_EN || paddr[1:0] != 2'b00))
		else $error("error flag does not match address");
	a_prdata_idle: assert property (!pready |-> prdata == 32'h0)
		else $error("read data outside answer");
	a_irq_modes: assert property (wake_irq |-> $past(power_mode) inside {`HVWK_MODE_NORMAL, `HVWK_MODE_STOP})
		else $error("interrupt outside active modes");
	a_wake_modes: assert property (wake_up_req |-> $past(power_mode) inside {`HVWK_MODE_SLEEP, `HVWK_MODE_FAILSAFE})
		else $error("wake request outside low power");
	a_wake_pulse: assert property (wake_up_req |=> !wake_up_req)
		else $error("wake request longer than a cycle");
	a_bias_excl: assert property (!(pull_up_en && pull_down_en))
		else $error("both current sources on");
endmodule
bind hvwk_top hvwk_checker #(.FILT_CYCLES(FILT_CYCLES), .FILT_CNT_W(FILT_CNT_W)) u_hvwk_checker (
	.mclk(mclk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.hv_wake_pin(hv_wake_pin), .fail_output_gp_pin(fail_output_gp_pin),
	.high_side_switch(high_side_switch), .power_mode(power_mode), .pull_up_en(pull_up_en),
	.pull_down_en(pull_down_en), .wake_irq(wake_irq), .wake_up_req(wake_up_req)
);
`default_nettype wire

// ===== testbench/hvwk_pin_model.sv
// far side of the wake pin: a switch or an open line
// assumes the bench changes drv_en and drv_val just after mclk edges
`timescale 1ns/1ps
`default_nettype none
module hvwk_pin_model (
	input  wire logic mclk,
	input  wire logic drv_en,
	input  wire logic drv_val,
	input  wire logic pull_up_en,
	input  wire logic pull_down_en,
	output var  logic pin
);
	initial pin = 1'b0;
	// an open line with no source wanders, so it toggles rather than hold a level
	always @(posedge mclk) begin
		if (drv_en)
			pin <= drv_val;
		else if (pull_up_en)
			pin <= 1'b1;
		else if (pull_down_en)
			pin <= 1'b0;
		else
			pin <= !pin;
	end
endmodule
`default_nettype wire

// ===== testbench/testbench.sv
// self-checking bench of the wake detector: register rows, then pin scenarios
// assumes hvwk_top with a short filter, the pin model and the bound checker
`timescale 1ns/1ps
`default_nettype none
`include "hvwk_consts.vh"
module testbench;
	localparam FC = 8;
	logic        mclk = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, rd;
	logic        pready, pslverr, err, hv_wake_pin, alt_pin = 0, hs = 0;
	logic [2:0]  mode = 0;
	logic        pull_up_en, pull_down_en, wake_irq, wake_up_req, drv_en = 1, drv_val = 0;
	int          fail_count = 0, tests_run = 0, wakes = 0, n0;
	// write flag, address, write data, expected read data
	logic [76:0] rows [10] = '{
		{1'b0, 12'h000, 32'h0, 32'h0}, {1'b0, 12'h010, 32'h0, 32'h0},
		{1'b0, 12'h018, 32'h0, 32'h0}, {1'b1, 12'h010, 32'h3, 32'h0},
		{1'b0, 12'h010, 32'h0, 32'h3}, {1'b1, 12'h004, 32'h1, 32'h0},
		{1'b0, 12'h004, 32'h0, 32'h0}, {1'b1, 12'h01c, 32'h5, 32'h0},
		{1'b1, 12'h000, 32'hffffffff, 32'h0}, {1'b0, 12'h000, 32'h0, 32'h7}};
	always #5 mclk = ~mclk;
	hvwk_top #(.FILT_CYCLES(FC), .FILT_CNT_W(4)) u_hvwk_top (
		.mclk(mclk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.hv_wake_pin(hv_wake_pin), .fail_output_gp_pin(alt_pin), .high_side_switch(hs),
		.power_mode(mode), .pull_up_en(pull_up_en), .pull_down_en(pull_down_en),
		.wake_irq(wake_irq), .wake_up_req(wake_up_req));
	hvwk_pin_model u_hvwk_pin_model (.mclk(mclk), .drv_en(drv_en), .drv_val(drv_val),
		.pull_up_en(pull_up_en), .pull_down_en(pull_down_en), .pin(hv_wake_pin));
	always @(posedge mclk) if (wake_up_req === 1'b1) wakes <= wakes + 1;
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			fail_count++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task stop_test;
		$display("comparisons %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task cyc(input int n);
		repeat (n) @(posedge mclk);
	endtask
	// one idle cycle after each transfer keeps a signal from two drives in one step
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1;
		n = 0;
		do begin
			@(posedge mclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20) begin
			fail_count++;
			stop_test;
		end
		rd = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
		@(posedge mclk);
	endtask
	task rchk(input logic [11:0] a, input logic [31:0] e);
		apb(0, a, 0);
		chk(rd, e);
	endtask
	task win;
		hs <= 1;
		cyc(3);
		hs <= 0;
		cyc(3);
	endtask
	initial begin
		#900000;
		fail_count++;
		stop_test;
	end
	initial begin
		cyc(16);
		sys_rst <= 0;
		@(posedge mclk);
		chk({wake_irq, wake_up_req, pull_up_en, pull_down_en}, 0);
		foreach (rows[i]) begin
			apb(rows[i][76], rows[i][75:64], rows[i][63:32]);
			chk(rd, rows[i][31:0]);
			chk(err, rows[i][75:64] > 12'h018);
		end
		$display("test registers done");
		apb(1, 12'h000, 0);
		for (int b = 0; b < 4; b++) begin
			apb(1, 12'h010, b);
			cyc(1);
			chk({pull_up_en, pull_down_en}, b == 3 ? 1 : b);
		end
		drv_val <= 1;
		cyc(FC + 10);
		chk({pull_up_en, pull_down_en}, 2);
		drv_en <= 0;
		cyc(20);
		rchk(12'h00c, 1);
		drv_en <= 1;
		$display("test bias done");
		apb(1, 12'h018, 1);
		apb(1, 12'h000, 1);
		apb(1, 12'h014, 3);
		drv_val <= 0;
		cyc(FC - 3);
		drv_val <= 1;
		cyc(FC + 10);
		rchk(12'h004, 0);
		chk(wake_irq, 0);
		drv_val <= 0;
		cyc(FC + 10);
		rchk(12'h004, 1);
		chk(wake_irq, 1);
		rchk(12'h00c, 0);
		apb(1, 12'h018, 0);
		cyc(2);
		chk(wake_irq, 0);
		apb(1, 12'h018, 1);
		apb(1, 12'h014, 1);
		cyc(2);
		chk(wake_irq, 0);
		drv_val <= 1;
		cyc(FC + 10);
		rchk(12'h004, 1);
		rchk(12'h00c, 1);
		apb(1, 12'h014, 1);
		apb(1, 12'h000, 0);
		drv_val <= 0;
		cyc(FC + 10);
		rchk(12'h004, 0);
		$display("test static done");
		apb(1, 12'h000, 1);
		for (int k = 0; k < 2; k++) begin
			mode <= k ? `HVWK_MODE_FAILSAFE : `HVWK_MODE_SLEEP;
			n0 = wakes;
			drv_val <= ~drv_val;
			cyc(FC + 10);
			chk(wakes - n0, 1);
			chk(wake_irq, 0);
			rchk(12'h00c, 0);
		end
		// init mode: level readable, event latched, but no interrupt and no wake-up
		mode <= `HVWK_MODE_INIT;
		n0 = wakes;
		drv_val <= 1;
		cyc(FC + 10);
		rchk(12'h00c, 1);
		chk(wakes - n0, 0);
		chk(wake_irq, 0);
		drv_val <= 0;
		cyc(FC + 10);
		apb(1, 12'h014, 3);
		mode <= `HVWK_MODE_NORMAL;
		$display("test low power done");
		apb(1, 12'h000, 4);
		alt_pin <= 1;
		cyc(FC - 3);
		alt_pin <= 0;
		cyc(FC + 10);
		rchk(12'h008, 0);
		alt_pin <= 1;
		cyc(FC + 10);
		rchk(12'h008, 1);
		apb(1, 12'h014, 3);
		$display("test alternate done");
		apb(1, 12'h000, 3);
		win;
		rchk(12'h004, 0);
		drv_val <= 1;
		cyc(FC + 10);
		rchk(12'h004, 0);
		rchk(12'h00c, 0);
		win;
		rchk(12'h004, 1);
		rchk(12'h00c, 1);
		chk(wake_irq, 1);
		$display("test cyclic done");
		// reset in mid-run with a flag pending and the interrupt high
		sys_rst <= 1;
		cyc(2);
		sys_rst <= 0;
		cyc(2);
		chk({wake_irq, wake_up_req, pull_up_en, pull_down_en}, 0);
		rchk(12'h000, 0);
		rchk(12'h004, 0);
		rchk(12'h010, 0);
		$display("test reset done");
		stop_test;
	end
endmodule
`default_nettype wire
